// >>> design/ams_top.sv
// Two-channel analog monitor selector and scaler.
// Assumes quantities and status synchronous to clk; converter takes millivolt codes.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module ams_top
	import ams_pkg::*;
(
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// Register port
	input  wire logic [ams_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [ams_pkg::DW-1:0]      reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [ams_pkg::DW-1:0]      reg_rdata,
	// Drive internals
	input  wire ams_pkg::ams_quant_t         quant,
	input  wire ams_pkg::ams_stat_t          stat,
	// Monitor converter
	output ams_pkg::ams_mon_t                mon
);
	import ams_pkg::*;

	// Default gain for each monitor type
	function automatic logic [GW-1:0] default_gain(input logic [TW-1:0] code);
		logic [GW-1:0] g;
		g = DEF_GAIN_NONE;
		case (code)
			T_MOTOR_VEL, T_CMD_VEL_PRE, T_CMD_VEL_INT, T_VEL_CTRL: g = DEF_GAIN_VEL;
			T_TORQUE, T_REGEN, T_OVERLOAD, T_POS_TLIM, T_NEG_TLIM: g = DEF_GAIN_PCT;
			T_PN_VOLT: g = DEF_GAIN_PN;
			T_SPEED_LIM, T_INERTIA: g = DEF_GAIN_VEL;
			T_CMD_DEV, T_ENC_DEV, T_FC_DEV, T_HYB_DEV: g = DEF_GAIN_DEV;
			T_ENC_TEMP, T_DRV_TEMP: g = DEF_GAIN_TEMP;
			T_SINGLE_TURN: g = DEF_GAIN_TURN;
			default: g = DEF_GAIN_NONE;
		endcase
		return g;
	endfunction

	// Quantity chosen by a type code; reserved and digital codes give zero
	function automatic logic signed [QW-1:0] select_quantity(
		input logic [TW-1:0]        code,
		input ams_quant_t           q,
		input ams_stat_t            s,
		input logic signed [QW-1:0] cmd_dev
	);
		logic signed [QW-1:0] v;
		v = '0;
		case (code)
			T_MOTOR_VEL:   v = q.motor_vel;
			T_CMD_VEL_PRE: v = q.cmd_vel_pre_filt;
			T_CMD_VEL_INT: v = q.cmd_vel_post_filt;
			T_VEL_CTRL:    v = q.vel_ctrl_cmd;
			T_TORQUE:      v = q.torque_cmd;
			T_CMD_DEV:     v = cmd_dev;
			T_ENC_DEV:     v = q.enc_dev;
			T_FC_DEV:      v = q.fc_dev;
			T_HYB_DEV:     v = q.hybrid_dev;
			T_PN_VOLT:     v = q.pn_voltage;
			T_REGEN:       v = q.regen_load;
			T_OVERLOAD:    v = q.overload;
			T_POS_TLIM:    v = q.pos_torque_lim;
			T_NEG_TLIM:    v = q.neg_torque_lim;
			T_SPEED_LIM:   v = q.speed_lim;
			T_INERTIA:     v = q.inertia_ratio;
			T_ENC_TEMP:    v = s.enc_20bit_inc ? q.enc_temp : '0;
			T_DRV_TEMP:    v = q.drv_temp;
			// Index not yet seen on an incremental encoder: hold zero
			T_SINGLE_TURN: v = (s.enc_incremental && !s.z_phase_seen) ? '0 : q.single_turn;
			default:       v = '0;
		endcase
		return v;
	endfunction

	// Clamp a scaled millivolt value into the chosen format
	function automatic logic [MVW:0] format_mv(
		input logic signed [NW-1:0] mv,
		input logic [1:0]           fmt
	);
		logic signed [NW-1:0] c;
		logic signed [NW-1:0] r;
		logic                 clip;
		c = mv;
		clip = 1'b0;
		if (mv > MV_FULL) begin
			c = MV_FULL;
			clip = 1'b1;
		end else if (mv < -MV_FULL) begin
			c = -MV_FULL;
			clip = 1'b1;
		end
		case (fmt)
			FMT_ABS:    r = (c < 0) ? -c : c;
			FMT_OFFSET: r = MV_CENTER + (c >>> 1);
			default:    r = c;
		endcase
		return {clip, r[MVW-1:0]};
	endfunction

	// Shared settings and read data
	logic [1:0] format_ff;
	logic       dir_ff;
	logic [DW-1:0] rdata_ff;

	// Per-channel results
	logic [NCH-1:0][MVW-1:0] mv_ff;
	logic [NCH-1:0]          clip_ff;
	logic [NCH-1:0]          dighi_ff;
	logic [NCH-1:0][TW-1:0]  type_rd;
	logic [NCH-1:0][GW-1:0]  gain_rd;

	// Command-unit deviation, rescaled from encoder or full-closed deviation
	logic signed [QW-1:0]       dev_src;
	logic signed [2*QW:0]       dev_prod;
	logic signed [QW-1:0]       cmd_dev;
	assign dev_src  = stat.full_closed ? quant.fc_dev : quant.enc_dev;
	assign dev_prod = dev_src * $signed({1'b0, stat.cmd_ratio_q16});
	assign cmd_dev  = QW'(dev_prod >>> RATIO_FRAC);

	// Digital level for the travel command status code
	logic travel_zero;
	always_comb begin
		case (stat.mode)
			PROFILE_POSITION_MODE: travel_zero = !stat.profiling_active;
			CYCLIC_POSITION_MODE:  travel_zero = (stat.travel_cmd == '0);
			CYCLIC_VELOCITY_MODE:  travel_zero = (quant.vel_ctrl_cmd == '0);
			CYCLIC_TORQUE_MODE:    travel_zero = (quant.torque_cmd == '0);
			default:               travel_zero = 1'b0;
		endcase
	end

	// Gain status is high only on the first gain set
	logic first_gain;
	assign first_gain = (stat.gain_set == GAIN_SET_FIRST);

	// Write decode of shared settings
	logic wr_format;
	logic wr_dir;
	assign wr_format = reg_wr && (reg_addr == REG_FORMAT);
	assign wr_dir    = reg_wr && (reg_addr == REG_DIR);

	// Shared setting registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			format_ff <= RST_FORMAT;
			dir_ff    <= RST_DIR;
		end else begin
			if (wr_format)
				format_ff <= reg_wdata[1:0];
			if (wr_dir)
				dir_ff <= reg_wdata[0];
		end
	end

	// Two identical channels, each with its own type and gain
	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
			logic [TW-1:0]        type_ff;
			logic [GW-1:0]        gain_ff;
			logic signed [QW-1:0] val_ff;
			logic [GW-1:0]        geff_ff;
			logic                 dig_ff;
			logic                 dhi_ff;
			logic signed [QW-1:0] raw;
			logic signed [QW-1:0] val;
			logic [GW-1:0]        geff;
			logic                 is_dig;
			logic                 dhi;
			logic signed [NW-1:0] num;
			logic signed [NW-1:0] quo;
			logic [MVW:0]         fmt_res;
			logic [MVW-1:0]       nxt_mv;
			logic                 nxt_clip;
			logic                 wr_type;
			logic                 wr_gain;

			assign wr_type = reg_wr && (reg_addr == REG_TYPE_OFS[ch]);
			assign wr_gain = reg_wr && (reg_addr == REG_GAIN_OFS[ch]);

			// Stage one: pick, sign and gain
			assign raw = select_quantity(type_ff, quant, stat, cmd_dev);
			// Single-turn data keeps its own CCW-positive sense
			assign val = (dir_ff && (type_ff != T_SINGLE_TURN)) ? -raw : raw;
			assign geff = (gain_ff == '0) ? default_gain(type_ff) : gain_ff;
			assign is_dig = (type_ff == T_TRAVEL_STAT) || (type_ff == T_GAIN_STAT);
			// Digital codes ignore gain and format; software sets them sanely
			assign dhi = (type_ff == T_TRAVEL_STAT) ? travel_zero : first_gain;

			// Stage two: value per volt, in millivolts
			assign num = NW'(val_ff) * MV_PER_V;
			assign quo = num / $signed({{(NW-GW){1'b0}}, geff_ff});
			assign fmt_res = format_mv(quo, format_ff);
			assign nxt_mv = dig_ff ? (dhi_ff ? MV_DIG_HIGH : '0) : fmt_res[MVW-1:0];
			assign nxt_clip = !dig_ff && fmt_res[MVW];

			// Channel settings
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					type_ff <= RST_TYPE;
					gain_ff <= RST_GAIN;
				end else begin
					if (wr_type)
						type_ff <= reg_wdata[TW-1:0];
					if (wr_gain)
						gain_ff <= reg_wdata[GW-1:0];
				end
			end

			// Pipeline; the multiply, the divider and the format clamp sit in stage two for timing
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					val_ff  <= '0;
					geff_ff <= DEF_GAIN_NONE;
					dig_ff  <= 1'b0;
					dhi_ff  <= 1'b0;
				end else begin
					val_ff  <= val;
					geff_ff <= geff;
					dig_ff  <= is_dig;
					dhi_ff  <= dhi;
				end
			end

			// Converter value
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					mv_ff[ch]    <= '0;
					clip_ff[ch]  <= 1'b0;
					dighi_ff[ch] <= 1'b0;
				end else begin
					mv_ff[ch]    <= nxt_mv;
					clip_ff[ch]  <= nxt_clip;
					dighi_ff[ch] <= dig_ff && dhi_ff;
				end
			end

			assign type_rd[ch] = type_ff;
			assign gain_rd[ch] = gain_ff;
		end
	endgenerate

	// Read selection; unmapped addresses read zero
	logic [DW-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (reg_addr)
			REG_TYPE_OFS[0]: rd_mux = DW'(type_rd[0]);
			REG_GAIN_OFS[0]: rd_mux = DW'(gain_rd[0]);
			REG_TYPE_OFS[1]: rd_mux = DW'(type_rd[1]);
			REG_GAIN_OFS[1]: rd_mux = DW'(gain_rd[1]);
			REG_FORMAT:      rd_mux = DW'(format_ff);
			REG_DIR:         rd_mux = DW'(dir_ff);
			REG_OUT1:        rd_mux = DW'(mv_ff[0]);
			REG_OUT2:        rd_mux = DW'(mv_ff[1]);
			REG_STATUS:      rd_mux = DW'({clip_ff, dighi_ff});
			default:         rd_mux = '0;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdata_ff <= '0;
		else
			rdata_ff <= reg_rd ? rd_mux : '0;
	end

	assign reg_rdata = rdata_ff;
	assign mon.ch_mv = mv_ff;
endmodule

// >>> include/ams_pkg.sv
// Constants, types and register map of the analog monitor selector.
// Assumes a single 200 MHz clock domain and a plain register port.
package ams_pkg;
	// Widths
	localparam int DW     = 32;
	localparam int ADDR_W = 4;
	localparam int QW     = 32;
	localparam int GW     = 28;
	localparam int MVW    = 16;
	localparam int TW     = 5;
	localparam int NW     = 44;
	localparam int NCH    = 2;

	// Register offsets, chosen for the plain port
	localparam logic [ADDR_W-1:0] REG_TYPE_OFS [NCH] = '{4'h0, 4'h2};
	localparam logic [ADDR_W-1:0] REG_GAIN_OFS [NCH] = '{4'h1, 4'h3};
	localparam logic [ADDR_W-1:0] REG_FORMAT  = 4'h4;
	localparam logic [ADDR_W-1:0] REG_DIR     = 4'h5;
	localparam logic [ADDR_W-1:0] REG_OUT1    = 4'h6;
	localparam logic [ADDR_W-1:0] REG_OUT2    = 4'h7;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h8;

	// Reset values
	localparam logic [TW-1:0] RST_TYPE   = 5'h00;
	localparam logic [GW-1:0] RST_GAIN   = 28'h0000000;
	localparam logic [1:0]    RST_FORMAT = 2'h0;
	localparam logic          RST_DIR    = 1'b0;

	// Monitor type codes
	localparam logic [TW-1:0] T_MOTOR_VEL   = 5'h00;
	localparam logic [TW-1:0] T_CMD_VEL_PRE = 5'h01;
	localparam logic [TW-1:0] T_CMD_VEL_INT = 5'h02;
	localparam logic [TW-1:0] T_VEL_CTRL    = 5'h03;
	localparam logic [TW-1:0] T_TORQUE      = 5'h04;
	localparam logic [TW-1:0] T_CMD_DEV     = 5'h05;
	localparam logic [TW-1:0] T_ENC_DEV     = 5'h06;
	localparam logic [TW-1:0] T_FC_DEV      = 5'h07;
	localparam logic [TW-1:0] T_HYB_DEV     = 5'h08;
	localparam logic [TW-1:0] T_PN_VOLT     = 5'h09;
	localparam logic [TW-1:0] T_REGEN       = 5'h0A;
	localparam logic [TW-1:0] T_OVERLOAD    = 5'h0B;
	localparam logic [TW-1:0] T_POS_TLIM    = 5'h0C;
	localparam logic [TW-1:0] T_NEG_TLIM    = 5'h0D;
	localparam logic [TW-1:0] T_SPEED_LIM   = 5'h0E;
	localparam logic [TW-1:0] T_INERTIA     = 5'h0F;
	localparam logic [TW-1:0] T_ENC_TEMP    = 5'h13;
	localparam logic [TW-1:0] T_DRV_TEMP    = 5'h14;
	localparam logic [TW-1:0] T_SINGLE_TURN = 5'h15;
	localparam logic [TW-1:0] T_TRAVEL_STAT = 5'h17;
	localparam logic [TW-1:0] T_GAIN_STAT   = 5'h18;

	// Default gains, quantity per volt
	localparam logic [GW-1:0] DEF_GAIN_VEL   = 28'd500;
	localparam logic [GW-1:0] DEF_GAIN_PCT   = 28'd33;
	localparam logic [GW-1:0] DEF_GAIN_DEV   = 28'd3000;
	localparam logic [GW-1:0] DEF_GAIN_PN    = 28'd80;
	localparam logic [GW-1:0] DEF_GAIN_TEMP  = 28'd10;
	localparam logic [GW-1:0] DEF_GAIN_TURN  = 28'd110000;
	localparam logic [GW-1:0] DEF_GAIN_NONE  = 28'd1;

	// Output scale in millivolts, deviation ratio fraction bits and first gain set code
	localparam logic signed [NW-1:0] MV_PER_V  = 44'sd1000;
	localparam logic signed [NW-1:0] MV_FULL   = 44'sd10000;
	localparam logic signed [NW-1:0] MV_CENTER = 44'sd5000;
	localparam logic signed [MVW-1:0] MV_DIG_HIGH = 16'sd5000;
	localparam int RATIO_FRAC = 16;
	localparam logic [1:0] GAIN_SET_FIRST = 2'h0;

	// Output formats and control modes
	typedef enum logic [1:0] {FMT_SIGNED, FMT_ABS, FMT_OFFSET} ams_fmt_t;
	typedef enum logic [1:0] {
		PROFILE_POSITION_MODE, CYCLIC_POSITION_MODE, CYCLIC_VELOCITY_MODE, CYCLIC_TORQUE_MODE
	} ams_mode_t;

	// Internal quantities of the drive
	typedef struct packed {
		logic signed [QW-1:0] motor_vel;
		logic signed [QW-1:0] cmd_vel_pre_filt;
		logic signed [QW-1:0] cmd_vel_post_filt;
		logic signed [QW-1:0] vel_ctrl_cmd;
		logic signed [QW-1:0] torque_cmd;
		logic signed [QW-1:0] enc_dev;
		logic signed [QW-1:0] fc_dev;
		logic signed [QW-1:0] hybrid_dev;
		logic signed [QW-1:0] pn_voltage;
		logic signed [QW-1:0] regen_load;
		logic signed [QW-1:0] overload;
		logic signed [QW-1:0] pos_torque_lim;
		logic signed [QW-1:0] neg_torque_lim;
		logic signed [QW-1:0] speed_lim;
		logic signed [QW-1:0] inertia_ratio;
		logic signed [QW-1:0] enc_temp;
		logic signed [QW-1:0] drv_temp;
		logic signed [QW-1:0] single_turn;
	} ams_quant_t;

	// Drive status feeding the digital monitor codes, deviation rescaling and encoder gating
	typedef struct packed {
		ams_mode_t            mode;
		logic                 profiling_active;
		logic signed [QW-1:0] travel_cmd;
		logic [1:0]           gain_set;
		logic                 full_closed;
		logic                 enc_20bit_inc;
		logic                 enc_incremental;
		logic                 z_phase_seen;
		logic [QW-1:0]        cmd_ratio_q16;
	} ams_stat_t;

	// Monitor converter values, millivolts per channel
	typedef struct packed {
		logic [NCH-1:0][MVW-1:0] ch_mv;
	} ams_mon_t;
endpackage

// >>> sim/ams_checker.sv
// Checker of monitor port relations of the selector top.
// Assumes settings reach mon two edges after the write edge.
`timescale 1ns/1ps
module ams_checker
	import ams_pkg::*;
(
	// Clock and reset
	input wire logic                       clk,
	input wire logic                       rst,
	// Register port
	input wire logic [ams_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ams_pkg::DW-1:0]     reg_wdata,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	input wire logic [ams_pkg::DW-1:0]     reg_rdata,
	// Drive side and converter
	input wire ams_pkg::ams_quant_t        quant,
	input wire ams_pkg::ams_stat_t         stat,
	input wire ams_pkg::ams_mon_t          mon
);
	logic [TW-1:0]         t0_ff, nxt_t0;
	logic [1:0]            f_ff, nxt_f, calm_ff, nxt_calm;
	logic signed [MVW-1:0] m0;
	logic                  ok;
	// Shadow settings; any write restarts the settle count
	assign nxt_t0 = (reg_wr && reg_addr == REG_TYPE_OFS[0]) ? reg_wdata[TW-1:0] : t0_ff;
	assign nxt_f = (reg_wr && reg_addr == REG_FORMAT) ? reg_wdata[1:0] : f_ff;
	assign nxt_calm = reg_wr ? 2'h0 : calm_ff + {1'b0, calm_ff != 2'h3};
	assign m0 = mon.ch_mv[0];
	assign ok = calm_ff >= 2'h2; // Old settings may still drain before this
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{t0_ff, f_ff, calm_ff} <= '0;
		end else begin
			{t0_ff, f_ff, calm_ff} <= {nxt_t0, nxt_f, nxt_calm};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	fmt_readback_a: assert property (
		$past(reg_rd && reg_addr == REG_FORMAT) |-> reg_rdata == {30'h0, f_ff})
		else $error("format readback wrong");
	signed_range_a: assert property (
		m0 >= -MV_FULL && m0 <= MV_FULL) else $error("monitor beyond 10 V");
	abs_range_a: assert property (
		ok && f_ff == 2'h1 |-> m0 >= 16'sh0 && m0 <= MV_FULL)
		else $error("absolute format out of range");
	offset_range_a: assert property (
		ok && f_ff == 2'h2 |-> m0 >= 16'sh0 && m0 <= MV_FULL)
		else $error("offset format out of range");
	reserved_zero_a: assert property (
		ok && f_ff == 2'h0 && t0_ff inside {5'h10, 5'h11, 5'h12, 5'h16} |-> m0 == 16'sh0)
		else $error("reserved code not zero");
	// Status sampled two edges back is what the monitor shows now
	gain_status_a: assert property (
		ok && t0_ff == T_GAIN_STAT |->
		m0 == (($past(stat.gain_set, 2) == GAIN_SET_FIRST) ? MV_DIG_HIGH : 16'sh0))
		else $error("gain status level wrong");
	profile_state_a: assert property (
		ok && t0_ff == T_TRAVEL_STAT && $past(stat.mode, 2) == PROFILE_POSITION_MODE
		|-> m0 == ($past(stat.profiling_active, 2) ? 16'sh0 : MV_DIG_HIGH))
		else $error("profile status level wrong");
	cyclic_pos_a: assert property (
		ok && t0_ff == T_TRAVEL_STAT && $past(stat.mode, 2) == CYCLIC_POSITION_MODE
		|-> m0 == (($past(stat.travel_cmd, 2) == 0) ? MV_DIG_HIGH : 16'sh0))
		else $error("cyclic position level wrong");
	cyclic_vel_a: assert property (
		ok && t0_ff == T_TRAVEL_STAT && $past(stat.mode, 2) == CYCLIC_VELOCITY_MODE
		|-> m0 == (($past(quant.vel_ctrl_cmd, 2) == 0) ? MV_DIG_HIGH : 16'sh0))
		else $error("cyclic velocity level wrong");
endmodule
bind ams_top ams_checker i_ams_checker (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .quant, .stat, .mon);

// >>> sim/ams_meter.sv
// Converter model that samples the monitor codes each clock.
// Assumes millivolt codes; the reading lags by one clock.
`timescale 1ns/1ps
module ams_meter
	import ams_pkg::*;
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Codes in, reading out
	input  wire ams_pkg::ams_mon_t  mon,
	output ams_pkg::ams_mon_t       meas
);
	// One conversion per clock; cleared while held in reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meas <= '0;
		end else begin
			meas <= mon;
		end
	end
endmodule

// >>> sim/ams_top_bench.sv
// Bench of the monitor selector: registers, scaling, digital codes.
// Assumes the meter model reads the monitor outputs.
`timescale 1ns/1ps
module ams_top_bench;
	import ams_pkg::*;
	logic              clk, rst, reg_wr, reg_rd;
	logic [ADDR_W-1:0] reg_addr;
	logic [DW-1:0]     reg_wdata, reg_rdata;
	logic [18*QW-1:0]  qv;
	ams_stat_t         st;
	ams_mon_t          mon, meas;
	int                err_total, num_checks;
	ams_top i_ams_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .quant(qv), .stat(st),
		.mon(mon));
	ams_meter i_ams_meter (.clk(clk), .rst(rst), .mon(mon), .meas(meas));
	// Clock at 200 MHz
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DW-1:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic setq(input int k, input logic [QW-1:0] v);
		@(posedge clk);
		qv[(17 - k) * QW +: QW] <= v;
	endtask
	// Two pipeline edges, the meter's own lag and one spare edge
	task automatic mchk(input int ch, input int e);
		repeat (4) @(posedge clk);
		#1 chk({16'h0000, meas.ch_mv[ch]}, {16'h0000, 16'(e)});
	endtask
	task automatic t_regs();
		rd(REG_TYPE_OFS[0], 32'h0);
		rd(REG_GAIN_OFS[1], 32'h0);
		rd(REG_DIR, 32'h0);
		rd(4'hF, 32'h0);
		wr(REG_OUT1, 32'h1234);
		rd(REG_OUT1, 32'h0);
		wr(REG_FORMAT, 32'hFFFFFFFF);
		rd(REG_FORMAT, 32'h3);
		wr(REG_FORMAT, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_defaults();
		int cd[19] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 19, 20, 21};
		int dg[19] = '{500, 500, 500, 500, 33, 3000, 3000, 3000, 3000, 80, 33, 33, 33, 33,
			500, 500, 10, 10, 110000};
		int f;
		foreach (cd[i]) begin
			f = (cd[i] <= 5) ? cd[i] : (cd[i] <= 15) ? cd[i] - 1 : cd[i] - 4;
			wr(REG_TYPE_OFS[0], cd[i]);
			setq(f, 3 * dg[i]);
			mchk(0, 3000);
			setq(f, 0);
		end
		$display("test defaults done");
	endtask
	task automatic t_scale();
		wr(REG_TYPE_OFS[0], 32'h0);
		wr(REG_GAIN_OFS[0], 32'd100);
		wr(REG_GAIN_OFS[1], 32'd1000);
		setq(0, -300);
		mchk(0, -3000);
		mchk(1, -300);
		wr(REG_FORMAT, 32'h1);
		mchk(0, 3000);
		wr(REG_FORMAT, 32'h2);
		mchk(0, 3500);
		setq(0, 5000);
		mchk(0, 10000);
		setq(0, -5000);
		mchk(0, 0);
		wr(REG_FORMAT, 32'h0);
		mchk(0, -10000);
		rd(REG_STATUS, 32'h4);
		wr(REG_DIR, 32'h1);
		setq(0, -300);
		mchk(0, 3000);
		wr(REG_TYPE_OFS[0], 32'd21);
		setq(17, 300);
		mchk(0, 3000);
		wr(REG_DIR, 32'h0);
		wr(REG_GAIN_OFS[0], 32'h0);
		$display("test scale done");
	endtask
	task automatic t_enc();
		@(posedge clk);
		qv <= '0;
		st.enc_20bit_inc <= 1'b0;
		st.enc_incremental <= 1'b1;
		st.cmd_ratio_q16 <= 32'h00020000;
		wr(REG_TYPE_OFS[0], 32'd19);
		setq(15, 30);
		mchk(0, 0);
		wr(REG_TYPE_OFS[0], 32'd21);
		setq(17, 330000);
		mchk(0, 0);
		@(posedge clk);
		st.z_phase_seen <= 1'b1;
		mchk(0, 3000);
		wr(REG_TYPE_OFS[0], 32'd5);
		setq(5, 1500);
		mchk(0, 1000);
		@(posedge clk);
		st.full_closed <= 1'b1;
		setq(6, 4500);
		mchk(0, 3000);
		setq(1, 1000);
		setq(2, 2000);
		wr(REG_TYPE_OFS[0], 32'd1);
		mchk(0, 2000);
		wr(REG_TYPE_OFS[0], 32'd2);
		mchk(0, 4000);
		$display("test encoder done");
	endtask
	// The cause of the current mode says zero or not in turn; the others say the opposite
	task automatic t_digital();
		logic [3:0] zc;
		int rc[4] = '{16, 17, 18, 22};
		wr(REG_FORMAT, 32'h1);
		wr(REG_GAIN_OFS[0], 32'h1);
		wr(REG_TYPE_OFS[0], 32'(T_TRAVEL_STAT));
		for (int m = 0; m < 4; m++) begin
			for (int z = 0; z < 2; z++) begin
				zc = (z == 1) ? (4'h1 << m) : ~(4'h1 << m);
				@(posedge clk);
				st.mode <= ams_mode_t'(m);
				st.profiling_active <= !zc[0];
				st.travel_cmd <= zc[1] ? 32'sh0 : 32'sh7;
				qv[14*QW +: QW] <= zc[2] ? 32'h0 : 32'h7;
				qv[13*QW +: QW] <= zc[3] ? 32'h0 : 32'h7;
				mchk(0, z * 5000);
			end
		end
		wr(REG_TYPE_OFS[0], 32'(T_GAIN_STAT));
		for (int g = 0; g < 3; g++) begin
			@(posedge clk);
			st.gain_set <= 2'(g);
			mchk(0, (g == 0) ? 5000 : 0);
		end
		wr(REG_FORMAT, 32'h0);
		@(posedge clk);
		qv <= {18{32'h00000309}};
		foreach (rc[i]) begin
			wr(REG_TYPE_OFS[0], rc[i]);
			mchk(0, 0);
		end
		$display("test digital done");
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Main sequence after a 12-clock reset
	initial begin
		{rst, reg_wr, reg_rd} = 3'b100;
		reg_addr = '0;
		reg_wdata = '0;
		qv = '0;
		st = '0;
		st.cmd_ratio_q16 = 32'h00010000;
		st.enc_20bit_inc = 1'b1;
		err_total = 0;
		num_checks = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_defaults();
		t_scale();
		t_enc();
		t_digital();
		summarize();
	end
	// Watchdog: the tests need well under 5000 clocks
	initial begin
		#100000;
		err_total++;
		summarize();
	end
endmodule
